// ===== lcd_arb_cfg.svh
`ifndef LCD_ARB_CFG_SVH
`define LCD_ARB_CFG_SVH
// register byte addresses
`define ADDR_HOST_CMD 4'h0
`define ADDR_HOST_DATA 4'h4
`define ADDR_STATUS 4'h8
`define ADDR_CONFIG 4'hC
// instruction fields
`define RS_EXP 2'h0
`define RS_FUNC 2'h2
`define RS_DATA 2'h3
`define ARB_ADDR_OP 3'h3
`define FUNC8_NIB 4'h3
`define FUNC4_NIB 4'h2
`define ARB_LAST 5'h17
// timing
`define OSC_HZ 270000
`define CORE_HZ 100000000
`define BUSY_NS 37000
`define BUSY_CYC ((`BUSY_NS * (`CORE_HZ / 1000000)) / 1000)
`define DIV_ROW_9 9'd400
`define DIV_ROW_12 9'd400
`define DIV_ROW_17 9'd200
`define OSC_DIV ((`CORE_HZ + `OSC_HZ / 2) / `OSC_HZ)
`define COM_COUNT 17
`endif

// ===== lcd_arb_pkg.sv
package lcd_arb_pkg;
   typedef enum logic [1:0] {TGT_CHAR, TGT_USER, TGT_ARB} ram_target_t;
   typedef enum logic [1:0] {DUTY_9, DUTY_12, DUTY_17} duty_t;
   typedef struct packed {
      logic [1:0] rs;
      logic rw;
      logic [7:0] data;
   } host_cmd_t;
endpackage : lcd_arb_pkg

// ===== lcd_arb_ctrl.sv
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "lcd_arb_cfg.svh"
module lcd_arb_ctrl
   import lcd_arb_pkg::*;
#(
   parameter int ARB_DEPTH = 32
) (
   input wire logic CORE_CLK,            // 100 MHz clock
   input wire logic ARST_N,              // async reset, active low
   input wire logic [3:0] AVS_ADDRESS,   // byte address
   input wire logic AVS_READ,            // read request
   input wire logic AVS_WRITE,           // write request
   input wire logic [31:0] AVS_WRITEDATA, // write data
   output logic [31:0] AVS_READDATA,     // read data
   output logic AVS_WAITREQUEST,         // stall
   output logic [191:0] ARB_LINE,        // arbitrator line bytes 00..17
   output logic [16:0] COM_OFF,          // common forced display-off
   output logic FRAME_TICK,              // one pulse per frame
   output logic BUSY                     // busy flag
);
   // ************************************************************
   // state
   // ************************************************************
   logic [7:0] arb_mem [0:ARB_DEPTH-1];
   logic [191:0] arb_line, next_arb_line;
   logic [4:0] arb_addr, next_arb_addr;
   ram_target_t target, next_target;
   logic incr, next_incr;
   logic func_locked, next_func_locked;
   logic two_line, next_two_line;
   logic big_font, next_big_font;
   logic nibble_mode, next_nibble_mode;
   logic nib_half, next_nib_half;
   logic [3:0] nib_hi, next_nib_hi;
   logic busy, next_busy;
   logic [12:0] busy_cnt, next_busy_cnt;
   logic [31:0] rdata, next_rdata;
   logic wait_n, next_wait_n;
   logic stall, next_stall;
   logic [16:0] com_off, next_com_off;
   logic [8:0] osc_cnt, next_osc_cnt;
   logic [8:0] row_cnt, next_row_cnt;
   logic [4:0] line_cnt, next_line_cnt;
   logic frame, next_frame;
   logic mem_we;
   logic [7:0] mem_wd;
   host_cmd_t cmd;
   logic cmd_valid;
   logic [7:0] full_byte;

   function automatic logic [4:0] step_addr(input logic [4:0] a, input logic up);
      step_addr = up ? a + 5'h01 : a - 5'h01;
   endfunction : step_addr

   function automatic logic [16:0] off_mask(input logic two, input logic big);
      logic [16:0] m;
      m = 17'h00000;
      if (!two && !big) m = 17'h1FE00;
      if (!two && big) m = 17'h1F000;
      off_mask = m;
   endfunction : off_mask

   // ************************************************************
   // host command decode and register bus
   // ************************************************************
   always_comb begin
      next_arb_addr = arb_addr;
      next_target = target;
      next_incr = incr;
      next_func_locked = func_locked;
      next_two_line = two_line;
      next_big_font = big_font;
      next_nibble_mode = nibble_mode;
      next_nib_half = nib_half;
      next_nib_hi = nib_hi;
      next_busy = busy;
      next_busy_cnt = busy_cnt;
      next_rdata = rdata;
      next_wait_n = 1'b0;
      mem_we = 1'b0;
      mem_wd = 8'h00;
      cmd = AVS_WRITEDATA[10:0];
      cmd_valid = 1'b0;
      full_byte = cmd.data;
      if (busy) begin
         if (busy_cnt == 13'h0000) next_busy = 1'b0;
         else next_busy_cnt = busy_cnt - 13'h0001;
      end
      if ((AVS_READ || AVS_WRITE) && !wait_n) begin
         next_wait_n = 1'b1;
         next_rdata = 32'h00000000;
         if (AVS_WRITE && AVS_ADDRESS == `ADDR_CONFIG)
            next_incr = AVS_WRITEDATA[0];
         if (AVS_READ && AVS_ADDRESS == `ADDR_CONFIG)
            next_rdata = {27'h0, nibble_mode, func_locked, big_font, two_line, incr};
         if (AVS_READ && AVS_ADDRESS == `ADDR_STATUS)
            next_rdata = {24'h0, busy, 2'h0, arb_addr};
         if (AVS_WRITE && AVS_ADDRESS == `ADDR_HOST_CMD) begin
            if (nibble_mode) begin
               if (!nib_half) begin
                  next_nib_hi = cmd.data[7:4];
                  next_nib_half = 1'b1;
               end else begin
                  full_byte = {nib_hi, cmd.data[7:4]};
                  next_nib_half = 1'b0;
                  cmd_valid = 1'b1;
               end
            end else cmd_valid = 1'b1;
         end
         if (AVS_READ && AVS_ADDRESS == `ADDR_HOST_DATA) begin
            next_rdata = {24'h0, arb_mem[arb_addr]};
            if (!busy && target == TGT_ARB) next_arb_addr = step_addr(arb_addr, incr);
         end
         if (cmd_valid && !busy) begin
            if (cmd.rs == `RS_EXP && cmd.rw && full_byte[7:5] == `ARB_ADDR_OP) begin
               next_arb_addr = full_byte[4:0];
               next_target = TGT_ARB;
            end else if (cmd.rs == `RS_FUNC && !cmd.rw) begin
               if (full_byte[7:4] == `FUNC8_NIB) next_nibble_mode = 1'b0;
               else if (full_byte[7:4] == `FUNC4_NIB) next_nibble_mode = 1'b1;
               else if (full_byte[7:6] == 2'h1 && !func_locked) begin
                  next_nibble_mode = !full_byte[4];
                  next_two_line = full_byte[3];
                  next_big_font = full_byte[2];
                  next_func_locked = 1'b1;
               end
               if (full_byte[7] && full_byte[6]) next_target = TGT_CHAR;
               else if (full_byte[7:6] == 2'h2) next_target = TGT_USER;
            end else if (cmd.rs == `RS_DATA && !cmd.rw) begin
               if (target == TGT_ARB) begin
                  mem_we = 1'b1;
                  mem_wd = full_byte;
                  next_arb_addr = step_addr(arb_addr, incr);
               end
            end
            next_busy = 1'b1;
            next_busy_cnt = 13'(`BUSY_CYC);
         end
      end
      next_stall = !next_wait_n;
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         arb_addr <= 5'h00;
         target <= TGT_CHAR;
         incr <= 1'b1;
         func_locked <= 1'b0;
         two_line <= 1'b0;
         big_font <= 1'b0;
         nibble_mode <= 1'b0;
         nib_half <= 1'b0;
         nib_hi <= 4'h0;
         busy <= 1'b0;
         busy_cnt <= 13'h0000;
         rdata <= 32'h00000000;
         wait_n <= 1'b0;
         stall <= 1'b1;
      end else begin
         arb_addr <= next_arb_addr;
         target <= next_target;
         incr <= next_incr;
         func_locked <= next_func_locked;
         two_line <= next_two_line;
         big_font <= next_big_font;
         nibble_mode <= next_nibble_mode;
         nib_half <= next_nib_half;
         nib_hi <= next_nib_hi;
         busy <= next_busy;
         busy_cnt <= next_busy_cnt;
         rdata <= next_rdata;
         wait_n <= next_wait_n;
         stall <= next_stall;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (mem_we) arb_mem[arb_addr] <= mem_wd;
   end

   // ************************************************************
   // display line, commons and frame timing
   // ************************************************************
   always_comb begin
      next_arb_line = arb_line;
      if (mem_we && arb_addr <= `ARB_LAST)
         next_arb_line[arb_addr*8 +: 8] = mem_wd;
      next_com_off = off_mask(two_line, big_font);
      next_frame = 1'b0;
      next_osc_cnt = osc_cnt + 9'h001;
      next_row_cnt = row_cnt;
      next_line_cnt = line_cnt;
      if (osc_cnt == 9'(`OSC_DIV - 1)) begin
         next_osc_cnt = 9'h000;
         next_row_cnt = row_cnt + 9'h001;
         if (row_cnt == (two_line ? `DIV_ROW_17 : (big_font ? `DIV_ROW_12 : `DIV_ROW_9)) - 9'd1) begin
            next_row_cnt = 9'h000;
            next_line_cnt = line_cnt + 5'h01;
            if (line_cnt == (two_line ? 5'd16 : (big_font ? 5'd11 : 5'd8))) begin
               next_line_cnt = 5'h00;
               next_frame = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         arb_line <= 192'h0;
         com_off <= 17'h1FE00;
         osc_cnt <= 9'h000;
         row_cnt <= 9'h000;
         line_cnt <= 5'h00;
         frame <= 1'b0;
      end else begin
         arb_line <= next_arb_line;
         com_off <= next_com_off;
         osc_cnt <= next_osc_cnt;
         row_cnt <= next_row_cnt;
         line_cnt <= next_line_cnt;
         frame <= next_frame;
      end
   end

   assign AVS_READDATA = rdata;
   assign AVS_WAITREQUEST = stall;
   assign ARB_LINE = arb_line;
   assign COM_OFF = com_off;
   assign FRAME_TICK = frame;
   assign BUSY = busy;
endmodule : lcd_arb_ctrl

// ===== lcd_arb_ctrl_monitor.sv
`timescale 1ns/1ps
module lcd_arb_ctrl_monitor
   import lcd_arb_pkg::*;
(
   input wire logic CORE_CLK, // clock
   input wire logic ARST_N, // reset
   input wire logic [3:0] AVS_ADDRESS, // addr
   input wire logic AVS_READ, // rd
   input wire logic AVS_WRITE, // wr
   input wire logic [31:0] AVS_WRITEDATA, // wdata
   input wire logic [31:0] AVS_READDATA, // rdata
   input wire logic AVS_WAITREQUEST, // stall
   input wire logic [191:0] ARB_LINE, // line
   input wire logic [16:0] COM_OFF, // commons
   input wire logic FRAME_TICK, // frame
   input wire logic BUSY // busy
);
   default clocking @(posedge CORE_CLK);
   endclocking
   default disable iff (!ARST_N);
   logic [12:0] busy_len;
   logic [12:0] next_busy_len;
   logic cmd_wr;
   always_comb next_busy_len = BUSY ? busy_len + 13'h1 : 13'h0;
   assign cmd_wr = AVS_WRITE && AVS_ADDRESS == 4'h0;
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) busy_len <= 13'h0;
      else busy_len <= next_busy_len;
   end
   sequence req_s; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST; endsequence
   sequence ans_s; !AVS_WAITREQUEST ##1 AVS_WAITREQUEST; endsequence
   answer_once_a: assert property (req_s |=> ans_s) else $error("late answer");
   idle_stall_a: assert property (!(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST) else $error("idle answer");
   busy_len_a: assert property ($fell(BUSY) |-> busy_len inside {[3699:3701]}) else $error("busy time");
   busy_cause_a: assert property ($rose(BUSY) |-> cmd_wr || $past(cmd_wr)) else $error("busy cause");
   com_set_a: assert property (COM_OFF inside {17'h1FE00, 17'h1F000, 17'h0}) else $error("commons");
   com_lock_a: assert property ($changed(COM_OFF) |-> $past(COM_OFF) == 17'h1FE00) else $error("relock");
   frame_pulse_a: assert property (FRAME_TICK |=> !FRAME_TICK) else $error("frame pulse");
   arb_cause_a: assert property ($changed(ARB_LINE) |-> $past(cmd_wr && AVS_WRITEDATA[10:8] == 3'h6))
      else $error("line cause");
   arb_busy_a: assert property ($changed(ARB_LINE) |-> !($past(BUSY) && $past(BUSY, 2)))
      else $error("busy write");
endmodule : lcd_arb_ctrl_monitor
bind lcd_arb_ctrl lcd_arb_ctrl_monitor mon (.*);

// ===== lcd_arb_host.sv
`timescale 1ns/1ps
module lcd_arb_host
   import lcd_arb_pkg::*;
(
   input wire logic CORE_CLK, // clock
   output logic [3:0] AVS_ADDRESS, // addr
   output logic AVS_READ, // rd
   output logic AVS_WRITE, // wr
   output logic [31:0] AVS_WRITEDATA, // wdata
   input wire logic [31:0] AVS_READDATA, // rdata
   input wire logic AVS_WAITREQUEST // stall
);
   logic chk = 1'b0;
   logic [31:0] rq;
   initial begin
      AVS_ADDRESS = 4'h0;
      AVS_READ = 1'b0;
      AVS_WRITE = 1'b0;
      AVS_WRITEDATA = 32'h0;
   end
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic c);
      @(posedge CORE_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      chk <= c;
      do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
      rq = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      chk <= 1'b0;
   endtask : bus
   // busy polling stands in for the fixed waits
   task cmd(input logic [1:0] rs, input logic rw, input logic [7:0] d, input logic poll);
      bus(1'b1, 4'h0, {21'h0, rs, rw, d}, 1'b0);
      if (poll) begin
         do bus(1'b0, 4'h8, 32'h0, 1'b0); while (rq[7] !== 1'b0);
      end
   endtask : cmd
endmodule : lcd_arb_host

// ===== test_lcd_arb_ctrl.sv
`timescale 1ns/1ps
module test_lcd_arb_ctrl;
   import lcd_arb_pkg::*;
   logic CORE_CLK;
   logic ARST_N;
   logic [3:0] AVS_ADDRESS;
   logic AVS_READ;
   logic AVS_WRITE;
   logic [31:0] AVS_WRITEDATA;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST;
   logic [191:0] ARB_LINE;
   logic [16:0] COM_OFF;
   logic FRAME_TICK;
   logic BUSY;
   logic [191:0] saved;
   logic [31:0] seed = 32'd87;
   logic [7:0] b;
   logic [31:0] exp_q[$];
   int mismatches = 0;
   int samples_checked = 0;
   int cyc = 0;
   lcd_arb_ctrl DUT (.*);
   lcd_arb_host host (.*);
   initial begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end
   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : xs
   task automatic check(input logic [191:0] seen, input logic [191:0] want);
      samples_checked++;
      if (seen !== want) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         mismatches++;
         results();
      end
      if (host.chk && AVS_READ && AVS_WAITREQUEST === 1'b0) begin
         check(192'(AVS_READDATA), 192'(exp_q.pop_front()));
      end
   end
   initial begin
      ARST_N = 1'b0;
      repeat (3) @(posedge CORE_CLK);
      ARST_N <= 1'b1;
      repeat (4) @(posedge CORE_CLK);
      for (int i = 0; i < 3; i++) begin
         b = xs();
         host.cmd(2'h2, 1'b0, {4'h3, b[3:0]}, 1'b1);
      end
      check(192'(COM_OFF), 192'(17'h1FE00));
      host.cmd(2'h2, 1'b0, 8'h54, 1'b1);
      check(192'(COM_OFF), 192'(17'h1F000));
      host.cmd(2'h2, 1'b0, 8'h58, 1'b1);
      check(192'(COM_OFF), 192'(17'h1F000));
      host.bus(1'b1, 4'hC, 32'h1, 1'b0);
      exp_q.push_back(32'hD);
      host.bus(1'b0, 4'hC, 32'h0, 1'b1);
      $display("test init done");
      host.cmd(2'h0, 1'b1, 8'h76, 1'b1);
      exp_q.push_back(32'h16);
      host.bus(1'b0, 4'h8, 32'h0, 1'b1);
      b = xs();
      host.cmd(2'h3, 1'b0, b, 1'b1);
      check(192'(ARB_LINE[176 +: 8]), 192'(b));
      b = xs();
      host.cmd(2'h3, 1'b0, b, 1'b1);
      check(192'(ARB_LINE[184 +: 8]), 192'(b));
      saved = ARB_LINE;
      b = xs();
      host.cmd(2'h3, 1'b0, b, 1'b1);
      check(ARB_LINE, saved);
      host.cmd(2'h0, 1'b1, 8'h78, 1'b1);
      exp_q.push_back({24'h0, b});
      host.bus(1'b0, 4'h4, 32'h0, 1'b1);
      $display("test arbitrator done");
      host.cmd(2'h0, 1'b1, 8'h65, 1'b0);
      host.cmd(2'h0, 1'b1, 8'h69, 1'b1);
      exp_q.push_back(32'h5);
      host.bus(1'b0, 4'h8, 32'h0, 1'b1);
      b = xs();
      host.cmd(2'h3, 1'b0, b, 1'b1);
      check(192'(ARB_LINE[40 +: 8]), 192'(b));
      host.cmd(2'h2, 1'b0, 8'hC0, 1'b1);
      saved = ARB_LINE;
      host.cmd(2'h3, 1'b0, xs(), 1'b1);
      check(ARB_LINE, saved);
      exp_q.push_back(32'h0);
      host.bus(1'b0, 4'h2, 32'h0, 1'b1);
      $display("test busy done");
      host.cmd(2'h2, 1'b0, 8'h20, 1'b1);
      host.cmd(2'h0, 1'b1, 8'h70, 1'b1);
      host.cmd(2'h0, 1'b1, 8'h00, 1'b1);
      b = xs();
      host.cmd(2'h3, 1'b0, {b[7:4], 4'h0}, 1'b1);
      host.cmd(2'h3, 1'b0, {b[3:0], 4'h0}, 1'b1);
      check(192'(ARB_LINE[128 +: 8]), 192'(b));
      $display("test nibble done");
      results();
   end
endmodule : test_lcd_arb_ctrl
